/* File: fdi_flash_download_init.sv */
/*
 * flash download control and programming/erasing initialization stages:
 * copies a built-in routine into a 2-kbyte ram region, checks it back,
 * writes the download result byte, and checks the cpu frequency parameter.
 * assumes: cpu-side inputs are on clk; external ram answers a read one
 * cycle after the request appears on ramReq and is frozen with clkEn too.
 */
// Notes on behaviour
// - a start pulse copies the chosen routine into 2 kbytes at the destination base
// - the download result byte lands in the first byte of the region last
// - bit 2 set when zero, several or an unmapped routine is selected
// - bit 1 set when the flash key register is not a5
// - bit 0 is success or failure, set with bit 2 or bit 1, else judged by reading the copy back
// - the routine times pulses by cpu loops so it needs the frequency
// - init sets bit 1 when the frequency is out of range
// - init bit 0 is zero when no error, one when an error occurred
// - only the low result register changes; stack use stays within 128 bytes
// - destination codes 04 and above set the destination error and abort
`timescale 1ns/1ps
`default_nettype none
`include "fdi_flash_map.svh"

module fdi_flash_download_init #(
   parameter int PROG_NUM  = 2,
   parameter int PROG_BITS = 1
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  clkEn,
   // download control from the cpu
   input  wire logic                  downloadStart,
   input  wire logic [6:0]            transferDest,
   input  wire logic [7:0]            flashKey,
   input  wire logic [PROG_NUM-1:0]   progSelect,
   input  wire logic [PROG_NUM-1:0]   progMapped,
   // initialization from the cpu
   input  wire logic                  initStart,
   input  wire logic [31:0]           cpuFreqParam,
   // on-chip ram port
   output fdi_pkg::fdi_ram_req_t      ramReq,
   input  wire logic [7:0]            ramRdData,
   // status back to the cpu
   output logic                       busy,
   output logic                       downloadDone,
   output logic                       initDone,
   output logic                       destErrorFlag,
   output logic [7:0]                 lowResult
);

   fdi_pkg::fdi_state_t           state_ff, nxt_state;
   logic [11:0]                   idx_ff, nxt_idx;
   logic [`FDI_RAM_ADDR_BITS-1:0] base_ff, nxt_base;
   logic [PROG_BITS-1:0]          prog_ff, nxt_prog;
   logic                          mism_ff, nxt_mism;
   logic [7:0]                    result_ff, nxt_result;
   fdi_pkg::fdi_ram_req_t         ramReq_ff, nxt_ramReq;
   logic                          dlDone_ff, nxt_dlDone;
   logic                          initDone_ff, nxt_initDone;
   logic                          destErr_ff, nxt_destErr;
   logic [7:0]                    lowRes_ff, nxt_lowRes;
   logic                          busy_ff, nxt_busy;
   logic [PROG_BITS+`FDI_OFS_BITS-1:0] romAddr;
   logic [7:0]                    romData;
   logic [PROG_BITS-1:0]          selIdx;
   logic                          srcErr;
   logic                          keyErr;
   logic                          freqErr;
   logic [`FDI_OFS_BITS-1:0]      romOfs;

   // routine store
   fdi_routine_rom #(
      .PROG_BITS (PROG_BITS)
   ) u_rom (
      .clk    (clk),
      .reset  (reset),
      .clkEn  (clkEn),
      .rdAddr (romAddr),
      .rdData (romData)
   );

   // selection, key and frequency checks
   always_comb begin
      int cnt;
      cnt    = 0;
      selIdx = '0;
      srcErr = 1'b0;
      for (int i = 0; i < PROG_NUM; i++) begin
         if (progSelect[i]) begin
            cnt    = cnt + 1;
            selIdx = PROG_BITS'(i);
            if (!progMapped[i]) begin
               srcErr = 1'b1;
            end
         end
      end
      if (cnt != 1) begin
         srcErr = 1'b1;
      end
      keyErr  = (flashKey != `FDI_KEY_OK);
      freqErr = (cpuFreqParam[31:16] != 16'h0000) ||
                (cpuFreqParam[15:0] < `FDI_FREQ_MIN) ||
                (cpuFreqParam[15:0] > `FDI_FREQ_MAX);
   end

   // routine address: copy reads ahead, verify lags by one to meet ram latency
   always_comb begin
      romOfs  = (state_ff == fdi_pkg::StVerify) ? 11'(idx_ff - 12'h001) : idx_ff[`FDI_OFS_BITS-1:0];
      romAddr = {prog_ff, romOfs};
   end

   // sequencer next state
   always_comb begin
      nxt_state    = state_ff;
      nxt_idx      = idx_ff;
      nxt_base     = base_ff;
      nxt_prog     = prog_ff;
      nxt_mism     = mism_ff;
      nxt_result   = result_ff;
      nxt_ramReq   = '0;
      nxt_dlDone   = 1'b0;
      nxt_initDone = 1'b0;
      nxt_destErr  = destErr_ff;
      nxt_lowRes   = lowRes_ff;
      case (state_ff)
         fdi_pkg::StIdle: begin
            if (downloadStart) begin
               nxt_state = fdi_pkg::StCheck;
            end else if (initStart) begin
               // result only in the low result register
               nxt_lowRes = 8'h00;
               nxt_lowRes[`FDI_INIT_FQ_BIT] = freqErr;
               nxt_lowRes[`FDI_INIT_SF_BIT] = freqErr;
               nxt_initDone = 1'b1;
            end
         end
         fdi_pkg::StCheck: begin
            nxt_idx  = 12'h000;
            nxt_mism = 1'b0;
            nxt_prog = selIdx;
            case (transferDest[1:0])
               2'h0:    nxt_base = `FDI_DEST_BASE0;
               2'h1:    nxt_base = `FDI_DEST_BASE1;
               2'h2:    nxt_base = `FDI_DEST_BASE2;
               default: nxt_base = `FDI_DEST_BASE3;
            endcase
            nxt_result = 8'h00;
            nxt_result[`FDI_DL_SS_BIT] = srcErr;
            nxt_result[`FDI_DL_FK_BIT] = keyErr;
            if (transferDest > `FDI_DEST_LAST) begin
               nxt_destErr = 1'b1;
               nxt_dlDone  = 1'b1;
               nxt_state   = fdi_pkg::StIdle;
            end else begin
               nxt_destErr = 1'b0;
               if (srcErr || keyErr) begin
                  nxt_result[`FDI_DL_SF_BIT] = 1'b1;
                  nxt_state = fdi_pkg::StWrite;
               end else begin
                  nxt_state = fdi_pkg::StCopy;
               end
            end
         end
         fdi_pkg::StCopy: begin
            // write the byte read from the store one cycle earlier
            if (idx_ff != 12'h000) begin
               nxt_ramReq.addr   = base_ff + `FDI_RAM_ADDR_BITS'(idx_ff - 12'h001);
               nxt_ramReq.wrData = romData;
               nxt_ramReq.wrEn   = 1'b1;
            end
            if (idx_ff == `FDI_REGION_BYTES) begin
               nxt_idx   = 12'h000;
               nxt_state = fdi_pkg::StVerify;
            end else begin
               nxt_idx = idx_ff + 12'h001;
            end
         end
         fdi_pkg::StVerify: begin
            // read back and compare against the store two cycles later
            if (idx_ff < `FDI_REGION_BYTES) begin
               nxt_ramReq.addr = base_ff + `FDI_RAM_ADDR_BITS'(idx_ff);
               nxt_ramReq.rdEn = 1'b1;
            end
            if (idx_ff >= 12'h002 && ramRdData != romData) begin
               nxt_mism = 1'b1;
            end
            if (idx_ff == `FDI_REGION_BYTES + 12'h001) begin
               nxt_result[`FDI_DL_SF_BIT] = mism_ff || (ramRdData != romData);
               nxt_state = fdi_pkg::StWrite;
            end else begin
               nxt_idx = idx_ff + 12'h001;
            end
         end
         fdi_pkg::StWrite: begin
            // result byte goes last so it is not overwritten by the copy
            nxt_ramReq.addr   = base_ff;
            nxt_ramReq.wrData = result_ff;
            nxt_ramReq.wrEn   = 1'b1;
            nxt_lowRes        = result_ff;
            nxt_dlDone        = 1'b1;
            nxt_state         = fdi_pkg::StIdle;
         end
         default: begin
            nxt_state = fdi_pkg::StIdle;
         end
      endcase
      // busy follows the next state so the output is a plain register
      nxt_busy = (nxt_state != fdi_pkg::StIdle);
   end

   // sequencer registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_ff    <= fdi_pkg::StIdle;
         idx_ff      <= 12'h000;
         base_ff     <= '0;
         prog_ff     <= '0;
         mism_ff     <= 1'b0;
         result_ff   <= 8'h00;
         ramReq_ff   <= '0;
         dlDone_ff   <= 1'b0;
         initDone_ff <= 1'b0;
         destErr_ff  <= 1'b0;
         lowRes_ff   <= 8'h00;
         busy_ff     <= 1'b0;
      end else if (clkEn) begin
         state_ff    <= nxt_state;
         idx_ff      <= nxt_idx;
         base_ff     <= nxt_base;
         prog_ff     <= nxt_prog;
         mism_ff     <= nxt_mism;
         result_ff   <= nxt_result;
         ramReq_ff   <= nxt_ramReq;
         dlDone_ff   <= nxt_dlDone;
         initDone_ff <= nxt_initDone;
         destErr_ff  <= nxt_destErr;
         lowRes_ff   <= nxt_lowRes;
         busy_ff     <= nxt_busy;
      end
   end

   // outputs straight from registers
   assign ramReq        = ramReq_ff;
   assign busy          = busy_ff;
   assign downloadDone  = dlDone_ff;
   assign initDone      = initDone_ff;
   assign destErrorFlag = destErr_ff;
   assign lowResult     = lowRes_ff;

endmodule

`default_nettype wire

/* File: fdi_flash_map.svh */
/*
 * addresses, field positions, limits and codes of the flash download and
 * initialization sequencer.
 * assumes: included by bare name from the package and the design modules.
 */
`ifndef FDI_FLASH_MAP_SVH
`define FDI_FLASH_MAP_SVH

// download region size and offset width inside it
`define FDI_REGION_BYTES   12'h800
`define FDI_OFS_BITS       11
`define FDI_RAM_ADDR_BITS  24

// start addresses selected by the transfer destination setting
`define FDI_DEST_BASE0     24'hff6000
`define FDI_DEST_BASE1     24'hff7000
`define FDI_DEST_BASE2     24'hff8000
`define FDI_DEST_BASE3     24'hff9000
`define FDI_DEST_LAST      7'h03

// correct flash key register value
`define FDI_KEY_OK         8'ha5

// download result byte fields
`define FDI_DL_SS_BIT      2
`define FDI_DL_FK_BIT      1
`define FDI_DL_SF_BIT      0

// init result byte fields
`define FDI_INIT_FQ_BIT    1
`define FDI_INIT_SF_BIT    0

// frequency parameter limits, MHz times 100
`define FDI_FREQ_MIN       16'h01f4
`define FDI_FREQ_MAX       16'h07d0

// most stack bytes a routine may use
`define FDI_STACK_MAX      8'h80

`endif

/* File: fdi_pkg.sv */
/*
 * types shared by the flash download and initialization sequencer.
 * assumes: fdi_flash_map.svh is on the include path.
 */
`include "fdi_flash_map.svh"

package fdi_pkg;

   // sequencer states
   typedef enum logic [2:0] {
      StIdle,
      StCheck,
      StCopy,
      StVerify,
      StWrite
   } fdi_state_t;

   // one request toward the on-chip ram
   typedef struct packed {
      logic [`FDI_RAM_ADDR_BITS-1:0] addr;
      logic [7:0]                    wrData;
      logic                          wrEn;
      logic                          rdEn;
   } fdi_ram_req_t;

endpackage

/* File: fdi_props.sv */
/*
 * port checker of the flash download and init sequencer.
 * assumes: bound into the sequencer; one clock, reset high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fdi_flash_map.svh"

module fdi_props (
   // clock and requests
   input wire logic                  clk,
   input wire logic                  reset,
   input wire logic                  clkEn,
   input wire logic                  downloadStart,
   input wire logic [6:0]            transferDest,
   input wire logic [7:0]            flashKey,
   input wire logic                  initStart,
   input wire logic [31:0]           cpuFreqParam,
   // answers
   input wire fdi_pkg::fdi_ram_req_t ramReq,
   input wire logic                  busy,
   input wire logic                  downloadDone,
   input wire logic                  initDone,
   input wire logic                  destErrorFlag,
   input wire logic [7:0]            lowResult
);
   logic freqBad;
   logic rsltWr;

   // frequency out of range or upper half set
   assign freqBad = (cpuFreqParam[31:16] != 16'h0000) || (cpuFreqParam[15:0] < `FDI_FREQ_MIN)
                    || (cpuFreqParam[15:0] > `FDI_FREQ_MAX);
   // result byte write at the end of a download
   assign rsltWr = downloadDone && ramReq.wrEn;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // init, refusal, destination, result byte and copy address checks
   chk_init_answer: assert property (initStart && !downloadStart && !busy && clkEn |=> initDone)
      else $error("init request not answered");
   chk_init_range: assert property (initStart && !downloadStart && !busy && clkEn |=> lowResult == {6'h00, $past(freqBad), $past(freqBad)})
      else $error("init result byte wrong");
   chk_busy_refuse: assert property (busy && initStart |=> !initDone)
      else $error("init taken while busy");
   chk_dest_abort: assert property ((downloadStart && !busy && clkEn) ##1 (clkEn && transferDest > `FDI_DEST_LAST) |=> downloadDone && destErrorFlag)
      else $error("prohibited destination not aborted");
   chk_abort_noram: assert property (downloadDone && destErrorFlag |-> !ramReq.wrEn && !ramReq.rdEn)
      else $error("ram touched on abort");
   chk_result_place: assert property (rsltWr |-> ramReq.addr[10:0] == 11'h000 && ramReq.wrData == lowResult && ramReq.wrData[7:3] == 5'h00)
      else $error("result byte misplaced");
   chk_fail_bit: assert property (rsltWr && (ramReq.wrData[2] || ramReq.wrData[1]) |-> ramReq.wrData[0])
      else $error("fail bit clear on error");
   chk_key_bit: assert property (rsltWr |-> ramReq.wrData[1] == (flashKey != `FDI_KEY_OK))
      else $error("key error bit wrong");
   chk_addr_step: assert property (ramReq.wrEn && $past(ramReq.wrEn) |-> ramReq.addr == $past(ramReq.addr) + 24'h000001)
      else $error("copy address not ascending");

   // main scenarios seen
   cov_abort: cover property (downloadDone && destErrorFlag);
   cov_good: cover property (rsltWr && ramReq.wrData == 8'h00);
   cov_freq_err: cover property (initDone && lowResult[1]);
endmodule

`default_nettype wire

/* File: fdi_ram_model.sv */
/*
 * on-chip ram model behind the sequencer's ram port.
 * assumes: reads answer one cycle after rdEn; frozen with clkEn.
 */
`timescale 1ns/1ps
`default_nettype none

module fdi_ram_model (
   // clock
   input wire logic                  clk,
   input wire logic                  clkEn,
   // ram port
   input wire fdi_pkg::fdi_ram_req_t ramReq,
   output logic [7:0]                ramRdData,
   // fault injection: flips bit 0 of read data
   input wire logic                  badRead
);
   logic [7:0] mem [0:65535];
   logic [7:0] rdq = 8'h5a;

   assign ramRdData = rdq;

   // writes land, reads answer next cycle, idle data toggles
   always @(posedge clk) begin
      if (clkEn) begin
         if (ramReq.wrEn) begin
            mem[ramReq.addr[15:0]] <= ramReq.wrData;
         end
         if (ramReq.rdEn) begin
            rdq <= mem[ramReq.addr[15:0]] ^ {7'h00, badRead};
         end else begin
            rdq <= ~rdq;
         end
      end
   end
endmodule

`default_nettype wire

/* File: fdi_routine_rom.sv */
/*
 * built-in routine store: one 2-kbyte image per downloadable routine,
 * read data out of a register one cycle after the address.
 * assumes: same clock and clock enable as the sequencer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fdi_flash_map.svh"

module fdi_routine_rom #(
   parameter int PROG_BITS = 1
) (
   // clock
   input  wire logic                              clk,
   input  wire logic                              reset,
   input  wire logic                              clkEn,
   // read port
   input  wire logic [PROG_BITS+`FDI_OFS_BITS-1:0] rdAddr,
   output logic      [7:0]                        rdData
);

   // image contents, a fixed table computed from the address
   function automatic logic [7:0] romByte(input logic [PROG_BITS+`FDI_OFS_BITS-1:0] a);
      logic [31:0] w;
      w = 32'(a) * 32'h0000009d;
      return w[7:0] ^ w[15:8];
   endfunction

   logic [7:0] nxt_rdData;

   // table lookup
   always_comb begin
      nxt_rdData = romByte(rdAddr);
   end

   // registered read data
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdData <= 8'h00;
      end else if (clkEn) begin
         rdData <= nxt_rdData;
      end
   end

endmodule

`default_nettype wire

/* File: testbench.sv */
/*
 * self-checking bench of the flash download and init sequencer.
 * assumes: ram model and checker compiled before this file.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic                  clk, reset, clkEn, downloadStart, initStart, badRead;
   logic                  busy, downloadDone, initDone, destErrorFlag;
   logic [6:0]            transferDest;
   logic [7:0]            flashKey, ramRdData, lowResult;
   logic [1:0]            progSelect, progMapped;
   logic [31:0]           cpuFreqParam;
   fdi_pkg::fdi_ram_req_t ramReq;
   int                    n_mismatch = 0;
   int                    cmp_count = 0;

   fdi_flash_download_init uut (.clk(clk), .reset(reset), .clkEn(clkEn), .downloadStart(downloadStart),
      .transferDest(transferDest), .flashKey(flashKey), .progSelect(progSelect), .progMapped(progMapped),
      .initStart(initStart), .cpuFreqParam(cpuFreqParam), .ramReq(ramReq), .ramRdData(ramRdData),
      .busy(busy), .downloadDone(downloadDone), .initDone(initDone), .destErrorFlag(destErrorFlag),
      .lowResult(lowResult));
   fdi_ram_model ram (.clk(clk), .clkEn(clkEn), .ramReq(ramReq), .ramRdData(ramRdData), .badRead(badRead));

   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task give_verdict;
      if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task cmp(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // expected routine byte at image address a
   function automatic logic [7:0] romByte(input logic [11:0] a);
      logic [15:0] p;
      p = a * 16'h009d;
      return p[7:0] ^ p[15:8];
   endfunction

   // init request, answer one cycle later
   task doInit(input logic [31:0] f, input logic [7:0] e);
      @(posedge clk);
      initStart <= 1'b1;
      cpuFreqParam <= f;
      @(posedge clk);
      initStart <= 1'b0;
      @(negedge clk);
      cmp({7'h00, initDone}, 8'h01);
      cmp(lowResult, e);
   endtask

   // download with an init request thrown in while busy
   task doLoad(input logic [6:0] d, input logic [7:0] k, input logic [1:0] s, m, input logic [7:0] e);
      int i;
      logic [15:0] b;
      b = 16'h6000 + {d[3:0], 12'h000};
      if (d < 7'h04) ram.mem[b] = 8'hff;
      @(posedge clk);
      downloadStart <= 1'b1;
      transferDest <= d;
      flashKey <= k;
      progSelect <= s;
      progMapped <= m;
      @(posedge clk);
      downloadStart <= 1'b0;
      initStart <= 1'b1;
      @(negedge clk);
      cmp({7'h00, busy}, 8'h01);
      @(posedge clk);
      initStart <= 1'b0;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (downloadDone !== 1'b1 && i < 5000);
      if (i >= 5000) begin
         n_mismatch++;
         give_verdict;
      end
      cmp(lowResult, e);
      cmp({7'h00, busy}, 8'h00);
      cmp({7'h00, destErrorFlag}, {7'h00, d > 7'h03});
      @(negedge clk);
      if (d < 7'h04) cmp(ram.mem[b], e);
   endtask

   // main sequence
   initial begin
      reset = 1'b1;
      clkEn = 1'b1;
      downloadStart = 1'b0;
      initStart = 1'b0;
      badRead = 1'b0;
      transferDest = 7'h00;
      flashKey = 8'h00;
      progSelect = 2'b00;
      progMapped = 2'b00;
      cpuFreqParam = 32'h00000000;
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      cmp(lowResult, 8'h00);
      doInit(32'h000001f4, 8'h00);
      doInit(32'h000001f3, 8'h03);
      doInit(32'h000007d0, 8'h00);
      doInit(32'h000007d1, 8'h03);
      doInit(32'h000103e8, 8'h03);
      // a low clock enable holds off a request
      @(posedge clk);
      clkEn <= 1'b0;
      initStart <= 1'b1;
      @(posedge clk);
      clkEn <= 1'b1;
      initStart <= 1'b0;
      @(negedge clk);
      cmp({7'h00, initDone}, 8'h00);
      doLoad(7'h00, 8'ha5, 2'b01, 2'b11, 8'h00);
      cmp(ram.mem[16'h6001], romByte(12'h001));
      cmp(ram.mem[16'h67ff], romByte(12'h7ff));
      doLoad(7'h03, 8'ha5, 2'b10, 2'b11, 8'h00);
      cmp(ram.mem[16'h9001], romByte(12'h801));
      doLoad(7'h01, 8'h5a, 2'b01, 2'b11, 8'h03);
      doLoad(7'h04, 8'ha5, 2'b01, 2'b11, 8'h03);
      doLoad(7'h7f, 8'ha5, 2'b01, 2'b11, 8'h03);
      doLoad(7'h02, 8'ha5, 2'b00, 2'b11, 8'h05);
      doLoad(7'h02, 8'ha5, 2'b11, 2'b11, 8'h05);
      doLoad(7'h02, 8'ha5, 2'b10, 2'b01, 8'h05);
      doLoad(7'h02, 8'h00, 2'b00, 2'b00, 8'h07);
      badRead <= 1'b1;
      doLoad(7'h01, 8'ha5, 2'b01, 2'b11, 8'h01);
      give_verdict;
   end
endmodule

bind fdi_flash_download_init fdi_props u_props (.clk(clk), .reset(reset), .clkEn(clkEn),
   .downloadStart(downloadStart), .transferDest(transferDest), .flashKey(flashKey), .initStart(initStart),
   .cpuFreqParam(cpuFreqParam), .ramReq(ramReq), .busy(busy), .downloadDone(downloadDone),
   .initDone(initDone), .destErrorFlag(destErrorFlag), .lowResult(lowResult));

`default_nettype wire
